// file: pkg/tuning_pkg.sv
// Constants, register map and types for the LED driver tuning register bank.
// Assumes a single 20 MHz clock domain and an AHB-Lite slave front end.
`default_nettype none
package tuning_pkg;
  // Bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Byte offsets of the 32-bit views of the registers
  localparam logic [7:0] OFS_TUNE_LO = 8'h00;
  localparam logic [7:0] OFS_TUNE_HI = 8'h04;
  localparam logic [7:0] OFS_LSEL_LO = 8'h08;
  localparam logic [7:0] OFS_LSEL_HI = 8'h0C;
  localparam logic [7:0] OFS_RB_CTRL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // Tuning word: 48 bits, reserved fields included and writable
  localparam int unsigned TUNE_W = 48;
  localparam int unsigned TUNE_HI_W = 16;
  localparam logic [47:0] TUNE_RST = 48'h0800_0540_403C;

  // Field positions in the tuning word
  localparam int unsigned B_CUTOFF = 0;
  localparam int unsigned B_CURRENT_RANGE_SELECT = 1;
  localparam int unsigned B_SCANREV = 14;
  localparam int unsigned B_FINE = 16;
  localparam int unsigned B_OFFSLEW = 19;
  localparam int unsigned B_ONSLEW = 22;
  localparam int unsigned B_COARSE = 32;
  localparam int unsigned B_DIM = 35;
  localparam int unsigned B_DEC2 = 39;
  localparam int unsigned B_DEC3 = 40;
  localparam int unsigned B_DEC3EN = 44;
  localparam int unsigned LEVEL_CODE_W = 4;
  localparam int unsigned NUM_COLOURS = 3;

  // Line select and readback control
  localparam int unsigned LSEL_W = 6;
  localparam logic [5:0] LSEL_RST = 6'h00;
  localparam logic RB_RST = 1'h0;
  localparam int unsigned NUM_LINES = 64;

  // Current limits per channel in mA
  localparam logic [4:0] ILIM_LOW_MA = 5'h0A;
  localparam logic [4:0] ILIM_HIGH_MA = 5'h14;

  typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_DONE} rd_state_t;
endpackage : tuning_pkg
`default_nettype wire

// file: pkg/cfg_bus_if.sv
// Internal register access strobes between the bus front end and the register bank.
// Assumes both ends run on hclk; strobes are one-cycle pulses.
`default_nettype none
interface cfg_bus_if;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;

  modport front (output wr, output rd, output addr, output wdata, input rdata);
  modport regs (input wr, input rd, input addr, input wdata, output rdata);
endinterface : cfg_bus_if
`default_nettype wire

// file: hw/ahb_cfg_slave.sv
// AHB-Lite slave front end: turns single word transfers into register strobes.
// Assumes the bus hready is this slave's hreadyout; writes take no wait, reads one.
`default_nettype none
module ahb_cfg_slave (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Register side
  cfg_bus_if.front bus
);
  logic accept;
  logic wr_pend_ff, nxt_wr_pend;
  logic [7:0] addr_ff, nxt_addr;
  logic [31:0] hrdata_ff, nxt_hrdata;
  tuning_pkg::rd_state_t rd_st_ff, nxt_rd_st;

  // Sub-word transfers are accepted but never write, so no lane is half updated
  assign accept = hsel & htrans[1] & hready;

  always_comb
  begin
    nxt_wr_pend = accept & hwrite & (hsize == tuning_pkg::HSIZE_WORD);
    nxt_addr = accept ? haddr[7:0] : addr_ff;
    nxt_hrdata = hrdata_ff;
    nxt_rd_st = rd_st_ff;
    case (rd_st_ff)
      tuning_pkg::RD_IDLE: if (accept & ~hwrite) nxt_rd_st = tuning_pkg::RD_WAIT;
      tuning_pkg::RD_WAIT:
      begin
        // Wait state lets a preceding write land before the read samples
        nxt_hrdata = bus.rdata;
        nxt_rd_st = tuning_pkg::RD_DONE;
      end
      tuning_pkg::RD_DONE: nxt_rd_st = (accept & ~hwrite) ? tuning_pkg::RD_WAIT : tuning_pkg::RD_IDLE;
      default: nxt_rd_st = tuning_pkg::RD_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      addr_ff <= 8'h00;
      hrdata_ff <= 32'h0000_0000;
      rd_st_ff <= tuning_pkg::RD_IDLE;
    end
    else
    begin
      wr_pend_ff <= nxt_wr_pend;
      addr_ff <= nxt_addr;
      hrdata_ff <= nxt_hrdata;
      rd_st_ff <= nxt_rd_st;
    end
  end

  assign bus.wr = wr_pend_ff;
  assign bus.rd = (rd_st_ff == tuning_pkg::RD_WAIT);
  assign bus.addr = addr_ff;
  assign bus.wdata = hwdata;
  assign hrdata = hrdata_ff;
  assign hreadyout = (rd_st_ff != tuning_pkg::RD_WAIT);
  assign hresp = 1'b0;
endmodule : ahb_cfg_slave
`default_nettype wire

// file: hw/scan_line_map.sv
// Maps a logical scan step onto the physical scan line for stacked boards.
// Assumes steps 0..31; the same map serves scanning and memory readout.
`default_nettype none
module scan_line_map (
  // Control
  input wire logic reverse,
  // Mapping
  input wire logic [4:0] step,
  output logic [4:0] line
);
  // Upper half runs 31 down to 16 when reversed
  assign line = (reverse & step[4]) ? {1'b1, ~step[3:0]} : step;
endmodule : scan_line_map
`default_nettype wire

// file: hw/led_driver_tuning_regs.sv
// Tuning and open-load line-select register bank of a matrix LED driver.
// Assumes an AHB-Lite master on hclk and chain/scan signals synchronous to hclk.
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`default_nettype none
// Summary of operation
// - With the cut-off bit set the last chip in the chain keeps its serial output off except during a read.
// - The current range bit picks 10 mA per channel when zero and 20 mA when one, resetting to zero.
// - The scan-reverse bit, resetting to one, runs the upper sixteen lines from 31 down to 16.
// - Bits 16 to 18 enable fine brightness compensation for red, green and blue, all off at reset.
// - Bits 32 to 34 enable coarse brightness compensation for red, green and blue, all off at reset.
// - Bits 19 to 21 pick slow or fast turn-off slew per colour, slow at reset.
// - Two-bit fields at 23-22, 25-24 and 27-26 pick turn-on slew from slowest to fastest, resetting to 01.
// - The first-line dimming code n at bits 38-35 gives level n plus one, level 1 at reset.
// - Bit 39 enables decoupling of on and off channels, off at reset.
// - The decoupling boost code n at bits 43-40 gives level n plus one, level 9 at reset.
// - Bit 44 turns the decoupling boost on, off at reset.
// - The six-bit line select picks which scan line's open-load warning is located, 0 to 63.
// - A separate enable bit gates open-load and short readback, off at reset.
module led_driver_tuning_regs (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Serial chain
  input wire logic is_last_chip,
  input wire logic cmd_is_read,
  input wire logic chain_shift_data,
  output logic chain_serial_out,
  output logic chain_serial_out_en,
  // Scan sequencing
  input wire logic [4:0] scan_step,
  output logic [4:0] scan_line_phys,
  // Open-load diagnostics
  input wire logic [63:0] open_load_warn,
  output logic [5:0] open_load_row_select,
  output logic fault_readback_en,
  output logic open_load_row_warn,
  // Analog tuning
  output logic last_chip_output_cutoff,
  output logic current_range_select,
  output logic [4:0] current_limit_ma,
  output logic scan_order_reverse,
  output logic [2:0] fine_comp_en,
  output logic [2:0] coarse_comp_en,
  output logic red_turnoff_slew,
  output logic green_turnoff_slew,
  output logic blue_turnoff_slew,
  output logic [1:0] red_turnon_slew,
  output logic [1:0] green_turnon_slew,
  output logic [1:0] blue_turnon_slew,
  output logic [4:0] first_line_dim_level,
  output logic on_off_channel_decouple_en,
  output logic [4:0] decouple_boost_level,
  output logic decouple_boost_en
);
  cfg_bus_if bus ();

  ahb_cfg_slave u_slave (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .bus(bus)
  );

  // Register state
  logic [47:0] tune_ff, nxt_tune;
  logic [5:0] lsel_ff, nxt_lsel;
  logic rb_en_ff, nxt_rb_en;

  // Whole reserved fields are stored, so software reads back what it wrote
  always_comb
  begin
    nxt_tune = tune_ff;
    nxt_lsel = lsel_ff;
    nxt_rb_en = rb_en_ff;
    if (bus.wr)
    begin
      case (bus.addr)
        tuning_pkg::OFS_TUNE_LO: nxt_tune[31:0] = bus.wdata;
        tuning_pkg::OFS_TUNE_HI: nxt_tune[47:32] = bus.wdata[15:0];
        tuning_pkg::OFS_LSEL_LO: nxt_lsel = bus.wdata[5:0];
        tuning_pkg::OFS_RB_CTRL: nxt_rb_en = bus.wdata[0];
        default: nxt_tune = tune_ff;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tune_ff <= tuning_pkg::TUNE_RST;
      lsel_ff <= tuning_pkg::LSEL_RST;
      rb_en_ff <= tuning_pkg::RB_RST;
    end
    else
    begin
      tune_ff <= nxt_tune;
      lsel_ff <= nxt_lsel;
      rb_en_ff <= nxt_rb_en;
    end
  end

  // Derived outputs, registered so they never glitch into the analog side
  logic [4:0] ilim_ff, nxt_ilim;
  logic [4:0] dim_ff, nxt_dim;
  logic [4:0] boost_ff, nxt_boost;
  logic ser_out_ff, nxt_ser_out;
  logic ser_oe_ff, nxt_ser_oe;
  logic row_warn_ff, nxt_row_warn;

  always_comb
  begin
    nxt_ilim = tune_ff[tuning_pkg::B_CURRENT_RANGE_SELECT] ? tuning_pkg::ILIM_HIGH_MA : tuning_pkg::ILIM_LOW_MA;
    nxt_dim = {1'b0, tune_ff[tuning_pkg::B_DIM +: tuning_pkg::LEVEL_CODE_W]} + 5'h01;
    nxt_boost = {1'b0, tune_ff[tuning_pkg::B_DEC3 +: tuning_pkg::LEVEL_CODE_W]} + 5'h01;
    nxt_ser_out = chain_shift_data;
    // A read must still reach the controller through the last chip
    nxt_ser_oe = ~(tune_ff[tuning_pkg::B_CUTOFF] & is_last_chip & ~cmd_is_read);
    nxt_row_warn = rb_en_ff & open_load_warn[lsel_ff];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ilim_ff <= tuning_pkg::ILIM_LOW_MA;
      dim_ff <= 5'h01;
      boost_ff <= 5'h09;
      ser_out_ff <= 1'b0;
      ser_oe_ff <= 1'b1;
      row_warn_ff <= 1'b0;
    end
    else
    begin
      ilim_ff <= nxt_ilim;
      dim_ff <= nxt_dim;
      boost_ff <= nxt_boost;
      ser_out_ff <= nxt_ser_out;
      ser_oe_ff <= nxt_ser_oe;
      row_warn_ff <= nxt_row_warn;
    end
  end

  // Output held low while cut off so the line idles at a known level
  assign chain_serial_out = ser_out_ff & ser_oe_ff;
  assign chain_serial_out_en = ser_oe_ff;
  assign current_limit_ma = ilim_ff;
  assign first_line_dim_level = dim_ff;
  assign decouple_boost_level = boost_ff;
  assign open_load_row_warn = row_warn_ff;
  assign open_load_row_select = lsel_ff;
  assign fault_readback_en = rb_en_ff;

  assign last_chip_output_cutoff = tune_ff[tuning_pkg::B_CUTOFF];
  assign current_range_select = tune_ff[tuning_pkg::B_CURRENT_RANGE_SELECT];
  assign scan_order_reverse = tune_ff[tuning_pkg::B_SCANREV];
  assign on_off_channel_decouple_en = tune_ff[tuning_pkg::B_DEC2];
  assign decouple_boost_en = tune_ff[tuning_pkg::B_DEC3EN];

  logic [2:0] off_slew;
  logic [5:0] on_slew;

  // Per-colour fields, red first
  genvar c;
  generate
    for (c = 0; c < tuning_pkg::NUM_COLOURS; c++)
    begin : g_colour
      assign fine_comp_en[c] = tune_ff[tuning_pkg::B_FINE + c];
      assign coarse_comp_en[c] = tune_ff[tuning_pkg::B_COARSE + c];
      assign off_slew[c] = tune_ff[tuning_pkg::B_OFFSLEW + c];
      assign on_slew[2*c +: 2] = tune_ff[tuning_pkg::B_ONSLEW + 2*c +: 2];
    end
  endgenerate

  assign red_turnoff_slew = off_slew[0];
  assign green_turnoff_slew = off_slew[1];
  assign blue_turnoff_slew = off_slew[2];
  assign red_turnon_slew = on_slew[1:0];
  assign green_turnon_slew = on_slew[3:2];
  assign blue_turnon_slew = on_slew[5:4];

  scan_line_map u_map (
    .reverse(tune_ff[tuning_pkg::B_SCANREV]),
    .step(scan_step),
    .line(scan_line_phys)
  );

  // Read mux; upper line-select bits and unmapped offsets read as zero
  always_comb
  begin
    bus.rdata = 32'h0000_0000;
    case (bus.addr)
      tuning_pkg::OFS_TUNE_LO: bus.rdata = tune_ff[31:0];
      tuning_pkg::OFS_TUNE_HI: bus.rdata = {16'h0000, tune_ff[47:32]};
      tuning_pkg::OFS_LSEL_LO: bus.rdata = {26'h000_0000, lsel_ff};
      tuning_pkg::OFS_LSEL_HI: bus.rdata = 32'h0000_0000;
      tuning_pkg::OFS_RB_CTRL: bus.rdata = {31'h0000_0000, rb_en_ff};
      tuning_pkg::OFS_STATUS: bus.rdata = {30'h0000_0000, ser_oe_ff, row_warn_ff};
      default: bus.rdata = 32'h0000_0000;
    endcase
  end
endmodule : led_driver_tuning_regs
`default_nettype wire

// file: dv/tuning_regs_monitor.sv
// Port checker for the tuning register bank.
// Assumes it is bound to the top module and sees only its ports.
`default_nettype none
module tuning_regs_monitor (
  // Clock, reset and bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Block pins
  input wire logic is_last_chip,
  input wire logic cmd_is_read,
  input wire logic chain_shift_data,
  input wire logic chain_serial_out,
  input wire logic chain_serial_out_en,
  input wire logic [4:0] scan_step,
  input wire logic [4:0] scan_line_phys,
  input wire logic [63:0] open_load_warn,
  input wire logic [5:0] open_load_row_select,
  input wire logic fault_readback_en,
  input wire logic open_load_row_warn,
  input wire logic last_chip_output_cutoff,
  input wire logic current_range_select,
  input wire logic [4:0] current_limit_ma,
  input wire logic scan_order_reverse,
  input wire logic decouple_boost_en
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  logic cut;
  assign take = hsel && htrans[1] && hready;
  assign cut = last_chip_output_cutoff && is_last_chip && !cmd_is_read;
  property p_cut; cut |=> !chain_serial_out_en && !chain_serial_out; endproperty
  a_cut: assert property (p_cut) else $error("serial output not cut off");
  property p_pass; !cut |=> chain_serial_out_en && chain_serial_out == $past(chain_shift_data); endproperty
  a_pass: assert property (p_pass) else $error("serial output not shifted");
  property p_current_range_select; current_limit_ma == ($past(current_range_select) ? 5'h14 : 5'h0A); endproperty
  a_current_range_select: assert property (p_current_range_select) else $error("current limit wrong");
  property p_scan; scan_line_phys == (scan_step ^ {1'b0, {4{scan_order_reverse & scan_step[4]}}}); endproperty
  a_scan: assert property (p_scan) else $error("scan line map wrong");
  property p_warn; open_load_row_warn == $past(fault_readback_en && open_load_warn[open_load_row_select]); endproperty
  a_warn: assert property (p_warn) else $error("row warning wrong");
  property p_rd; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_rd: assert property (p_rd) else $error("read wait not one cycle");
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  // Settings may only move two edges after a taken write
  property p_hold; !$past(take && hwrite, 2) |-> $stable(decouple_boost_en) && $stable(scan_order_reverse); endproperty
  a_hold: assert property (p_hold) else $error("setting changed without write");
  c_cut: cover property (cut);
  c_rd: cover property (take && !hwrite);
  c_rev: cover property (scan_order_reverse && scan_step[4]);
endmodule : tuning_regs_monitor
`default_nettype wire

// file: dv/ctrl_model.sv
// Display controller model: single AHB-Lite transfers of word or sub-word size.
// Assumes one slave whose hreadyout is the bus hready.
`default_nettype none
module ctrl_model (
  // Clock
  input wire logic hclk,
  // AHB-Lite master
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end
  task automatic xfer(input logic w, input logic [2:0] s, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= s;
    haddr <= {24'h00_0000, a};
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'b1 && n < 64);
    htrans <= 2'h0;
    hwdata <= d;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'b1 && n < 64);
    q = hrdata;
    ok = n < 64;
  endtask : xfer
endmodule : ctrl_model
`default_nettype wire

// file: dv/led_driver_tuning_regs_tb.sv
// Self-checking bench for the tuning register bank.
// Assumes the controller model drives the bus; the bench drives chain, scan and diagnostic pins.
`default_nettype none
module led_driver_tuning_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
    $display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
  int errors = 0;
  int cmp_count = 0;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, is_last_chip, cmd_is_read, chain_shift_data;
  logic chain_serial_out, chain_serial_out_en, fault_readback_en, open_load_row_warn, last_chip_output_cutoff;
  logic current_range_select, scan_order_reverse, red_turnoff_slew, green_turnoff_slew, blue_turnoff_slew;
  logic on_off_channel_decouple_en, decouple_boost_en;
  logic [1:0] htrans, red_turnon_slew, green_turnon_slew, blue_turnon_slew;
  logic [2:0] hsize, fine_comp_en, coarse_comp_en;
  logic [4:0] scan_step, scan_line_phys, current_limit_ma, first_line_dim_level, decouple_boost_level;
  logic [5:0] open_load_row_select;
  logic [31:0] haddr, hwdata, hrdata;
  logic [63:0] open_load_warn;
  led_driver_tuning_regs dut_u (.*, .hready(hreadyout));
  ctrl_model ctrl_u (.hclk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata);
  always #25 hclk = ~hclk;
  task automatic wrap_up(input bit hang);
    if (hang)
      errors++;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic ok;
    ctrl_u.xfer(1'b1, tuning_pkg::HSIZE_WORD, a, d, q, ok);
    if (!ok)
      wrap_up(1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    logic ok;
    ctrl_u.xfer(1'b0, tuning_pkg::HSIZE_WORD, a, 32'h0000_0000, q, ok);
    if (!ok)
      wrap_up(1'b1);
    `CHK(q, e)
  endtask : rd
  // Derived outputs settle one cycle after the register
  task automatic look;
    @(negedge hclk);
    @(negedge hclk);
  endtask : look
  task automatic t_reset;
    // Look off the edge so no output is read in the step that launches it
    @(negedge hclk);
    `CHK({current_limit_ma, first_line_dim_level, decouple_boost_level, scan_line_phys, current_range_select},
      {15'h2829, 5'h1E, 1'h0})
    @(posedge hclk);
    rd(8'h00, 32'h0540_403C);
    rd(8'h04, 32'h0000_0800);
    rd(8'h08, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
  endtask : t_reset
  task automatic t_fields(input logic [31:0] lo, input logic [31:0] hi);
    wr(8'h00, lo);
    wr(8'h04, hi);
    look;
    `CHK({current_limit_ma, current_range_select, scan_order_reverse, scan_line_phys, fine_comp_en, coarse_comp_en,
      red_turnoff_slew, green_turnoff_slew, blue_turnoff_slew, red_turnon_slew, green_turnon_slew, blue_turnon_slew,
      first_line_dim_level, on_off_channel_decouple_en, decouple_boost_level, decouple_boost_en,
      last_chip_output_cutoff}, {lo[1] ? 5'h14 : 5'h0A, lo[1], lo[14], lo[14] ? 5'h1E : 5'h11, lo[18:16], hi[2:0],
      lo[19], lo[20], lo[21], lo[23:22], lo[25:24], lo[27:26], {1'b0, hi[6:3]} + 5'h01, hi[7],
      {1'b0, hi[11:8]} + 5'h01, hi[12], lo[0]})
    @(posedge hclk);
    rd(8'h00, lo);
    rd(8'h04, {16'h0000, hi[15:0]});
  endtask : t_fields
  // A byte-wide write to offset 0x00 must leave the low tuning word as it stands
  task automatic t_subword(input logic [31:0] lo);
    logic [31:0] q;
    logic ok;
    ctrl_u.xfer(1'b1, 3'h0, 8'h00, 32'h0000_0000, q, ok);
    if (!ok)
      wrap_up(1'b1);
    rd(8'h00, lo);
  endtask : t_subword
  task automatic t_diag;
    open_load_warn <= 64'h8000_0000_0000_0002;
    wr(8'h10, 32'h0000_0001);
    wr(8'h08, 32'h0000_003F);
    look;
    `CHK({fault_readback_en, open_load_row_select, open_load_row_warn}, 8'hFF)
    @(posedge hclk);
    rd(8'h08, 32'h0000_003F);
    rd(8'h0C, 32'h0000_0000);
    rd(8'h14, 32'h0000_0003);
    wr(8'h08, 32'h0000_0001);
    look;
    `CHK({fault_readback_en, open_load_row_select, open_load_row_warn}, 8'h83)
    @(posedge hclk);
    wr(8'h10, 32'h0000_0000);
    look;
    `CHK({fault_readback_en, open_load_row_warn}, 2'h0)
  endtask : t_diag
  task automatic t_chain;
    logic [2:0] c;
    for (int i = 0; i < 8; i++)
    begin
      c = i[2:0];
      @(posedge hclk);
      is_last_chip <= c[2];
      cmd_is_read <= c[1];
      chain_shift_data <= c[0];
      look;
      `CHK({chain_serial_out_en, chain_serial_out}, (c[2] && !c[1]) ? 2'h0 : {1'b1, c[0]})
    end
    @(posedge hclk);
    cmd_is_read <= 1'b0;
    wr(8'h00, 32'h0540_403C);
    look;
    `CHK({chain_serial_out_en, chain_serial_out}, 2'h3)
  endtask : t_chain
  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    is_last_chip = 1'b0;
    cmd_is_read = 1'b0;
    chain_shift_data = 1'b0;
    scan_step = 5'h11;
    open_load_warn = 64'h0000_0000_0000_0000;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_fields(32'h0FFF_003F, 32'hFFFF_1FFF);
    t_fields(32'h0E11_403D, 32'h0000_002C);
    t_subword(32'h0E11_403D);
    t_diag;
    t_chain;
    wrap_up(1'b0);
  end
endmodule : led_driver_tuning_regs_tb
bind led_driver_tuning_regs tuning_regs_monitor mon_u (.*);
`default_nettype wire
